// ==== rtl/timer8_pwm.sv ====
/*
 * 8-bit timer/counter with fast and phase correct PWM generation.
 * Assumes one clock (clk, 40 MHz), synchronous active-high reset,
 * and a register port driven on the same clock.
 */
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps

module timer8_pwm (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic compare_output_pin,
	output logic compare_output_pin_oe,
	output logic overflow_flag,
	output logic compare_match_flag
);

	// --------------------------------------------------------------
	// configuration registers
	// --------------------------------------------------------------
	logic [7:0] ctrl;
	logic [7:0] compare_value;
	logic [7:0] compare_active;
	logic [7:0] counter_value;
	logic count_down;
	logic compare_output;
	logic [9:0] prescale;
	logic timer_clock_enable;
	logic match_block;

	logic [1:0] waveform_mode_sel;
	logic [1:0] compare_output_mode;
	logic [2:0] clock_sel;
	logic pin_is_output;

	assign waveform_mode_sel = ctrl[pwm_pkg::wgm_lsb +: 2];
	assign compare_output_mode = ctrl[pwm_pkg::com_lsb +: 2];
	assign clock_sel = ctrl[pwm_pkg::cs_lsb +: 3];
	assign pin_is_output = ctrl[pwm_pkg::dir_bit];

	logic wr_ctrl;
	logic wr_counter;
	logic wr_compare;
	logic wr_status;

	always_comb begin
		wr_ctrl = 1'b0;
		wr_counter = 1'b0;
		wr_compare = 1'b0;
		wr_status = 1'b0;
		if (reg_wr && reg_addr == pwm_pkg::ctrl_addr) begin
			wr_ctrl = 1'b1;
		end else if (reg_wr && reg_addr == pwm_pkg::counter_addr) begin
			wr_counter = 1'b1;
		end else if (reg_wr && reg_addr == pwm_pkg::compare_addr) begin
			wr_compare = 1'b1;
		end else if (reg_wr && reg_addr == pwm_pkg::status_addr) begin
			wr_status = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl <= pwm_pkg::ctrl_reset;
		end else if (wr_ctrl) begin
			ctrl <= reg_wdata;
		end
	end

	// software writes land here; see compare_active for the buffered copy
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			compare_value <= pwm_pkg::bottom;
		end else if (wr_compare) begin
			compare_value <= reg_wdata;
		end
	end

	// --------------------------------------------------------------
	// prescaler: single clock, tick is an enable pulse
	// --------------------------------------------------------------
	// divider runs on across a rate change, so the first tick
	// after a change may come up to one period early
	always_ff @(posedge clk) begin
		if (sys_rst || clock_sel == pwm_pkg::cs_stop) begin
			prescale <= 10'h000;
		end else begin
			prescale <= prescale + 10'h001;
		end
	end

	logic next_tick;

	always_comb begin
		next_tick = 1'b0;
		case (clock_sel)
			pwm_pkg::cs_div1: next_tick = 1'b1;
			pwm_pkg::cs_div8:
				next_tick = (prescale & pwm_pkg::div8_mask) ==
					pwm_pkg::div8_mask;
			pwm_pkg::cs_div64:
				next_tick = (prescale & pwm_pkg::div64_mask) ==
					pwm_pkg::div64_mask;
			pwm_pkg::cs_div256:
				next_tick = (prescale & pwm_pkg::div256_mask) ==
					pwm_pkg::div256_mask;
			// the 1024 step compares the full count; its mask covers all 10 bits, so a mask test gives the same
			pwm_pkg::cs_div1024:
				next_tick = prescale == pwm_pkg::div1024_mask;
			default: next_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			timer_clock_enable <= 1'b0;
		end else begin
			timer_clock_enable <= next_tick;
		end
	end

	// --------------------------------------------------------------
	// counter
	// --------------------------------------------------------------
	logic is_fast;
	logic is_phase;
	logic at_max;
	logic at_bottom;

	assign is_fast = waveform_mode_sel == pwm_pkg::wgm_fast;
	assign is_phase = waveform_mode_sel == pwm_pkg::wgm_phase;
	assign at_max = counter_value == pwm_pkg::max;
	assign at_bottom = counter_value == pwm_pkg::bottom;

	logic [7:0] next_count;
	logic next_down;

	always_comb begin
		next_count = counter_value;
		next_down = count_down;
		if (is_phase) begin
			// dual slope: one tick at MAX, then down; 510 ticks a period
			if (at_max) begin
				next_down = 1'b1;
				next_count = counter_value - 8'h01;
			end else if (count_down && at_bottom) begin
				next_down = 1'b0;
				next_count = counter_value + 8'h01;
			end else if (count_down) begin
				next_count = counter_value - 8'h01;
			end else begin
				next_count = counter_value + 8'h01;
			end
		end else if (is_fast && at_max) begin
			next_down = 1'b0;
			next_count = pwm_pkg::bottom;
		end else begin
			next_down = 1'b0;
			next_count = counter_value + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			counter_value <= pwm_pkg::bottom;
			count_down <= 1'b0;
		end else if (wr_counter) begin
			// a write beats a tick in the same cycle; direction kept
			counter_value <= reg_wdata;
		end else if (timer_clock_enable) begin
			counter_value <= next_count;
			count_down <= next_down;
		end
	end

	// a counter write blocks the match on the following tick
	// so a counter loaded equal to the compare raises no match
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			match_block <= 1'b0;
		end else if (wr_counter) begin
			match_block <= 1'b1;
		end else if (timer_clock_enable) begin
			match_block <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// buffered compare value: fast loads at BOTTOM, phase at TOP
	// --------------------------------------------------------------
	logic buffered;
	logic load_point;

	assign buffered = is_fast || is_phase;
	// both modes load on the MAX tick: in fast PWM that is the step
	// to BOTTOM, in phase correct it is TOP
	assign load_point = at_max;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			compare_active <= pwm_pkg::bottom;
		end else if (!buffered) begin
			compare_active <= compare_value;
		end else if (timer_clock_enable && load_point) begin
			compare_active <= compare_value;
		end
	end

	// --------------------------------------------------------------
	// waveform generator
	// --------------------------------------------------------------
	logic match;
	logic pwm_mode;
	logic invert;
	logic cmp_top;

	assign match = timer_clock_enable && !match_block &&
		counter_value == compare_active;
	assign pwm_mode = compare_output_mode[1];
	assign invert = compare_output_mode[0];
	assign cmp_top = compare_active == pwm_pkg::max;

	logic next_out;

	always_comb begin
		next_out = compare_output;
		if (timer_clock_enable && is_fast) begin
			if (pwm_mode) begin
				if (at_max) begin
					// set at BOTTOM even when the TOP match is ignored
					next_out = !invert;
				end else if (match) begin
					next_out = invert;
				end
			end else if (compare_output_mode == pwm_pkg::com_toggle &&
				match) begin
				next_out = !compare_output;
			end
		end else if (timer_clock_enable && is_phase && pwm_mode) begin
			if (at_max) begin
				// level at MAX is that of an up match, or of a down match when the
				// compare is MAX, covering a match that was missed or a compare leaving MAX
				next_out = cmp_top ? !invert : invert;
			end else if (match && !cmp_top) begin
				// BOTTOM turns the count round, so a match there acts
				// as an up match and a compare of zero stays low, or high when inverting
				if (count_down && !at_bottom) begin
					next_out = !invert;
				end else begin
					next_out = invert;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			compare_output <= 1'b0;
		end else begin
			compare_output <= next_out;
		end
	end

	// pin driven only when direction is output and a mode is chosen
	// pin takes next_out so it lands with the internal output
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			compare_output_pin <= 1'b0;
			compare_output_pin_oe <= 1'b0;
		end else begin
			compare_output_pin <= next_out;
			compare_output_pin_oe <= pin_is_output &&
				(compare_output_mode != pwm_pkg::com_off);
		end
	end

	// --------------------------------------------------------------
	// flags: set wins over a write-one clear
	// --------------------------------------------------------------
	logic ovf_event;

	assign ovf_event = timer_clock_enable &&
		(is_phase ? (count_down && at_bottom) : at_max);

	// a set in the clearing cycle wins, so no event is lost
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			overflow_flag <= 1'b0;
		end else if (ovf_event) begin
			overflow_flag <= 1'b1;
		end else if (wr_status && reg_wdata[pwm_pkg::ovf_bit]) begin
			overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			compare_match_flag <= 1'b0;
		end else if (match) begin
			compare_match_flag <= 1'b1;
		end else if (wr_status && reg_wdata[pwm_pkg::cmf_bit]) begin
			compare_match_flag <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// elaboration checks on the shared constants
	// --------------------------------------------------------------
	// period figures and count range must agree, or the waveform
	// and every cycle count built on the constants drift apart
	if (pwm_pkg::fast_period != int'(pwm_pkg::max) + 1) begin
		$error("fast period does not fit the counter range");
	end
	if (pwm_pkg::phase_period != 2 * int'(pwm_pkg::max)) begin
		$error("phase period does not fit the counter range");
	end
	if (pwm_pkg::div1024_mask != 10'h3FF) begin
		$error("prescaler too narrow for the largest division");
	end

	// --------------------------------------------------------------
	// read port: data in the cycle after the strobe
	// --------------------------------------------------------------
	// idle data reads zero, so a stray sample shows no flag set
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == pwm_pkg::ctrl_addr) begin
			reg_rdata <= ctrl;
		end else if (reg_addr == pwm_pkg::counter_addr) begin
			reg_rdata <= counter_value;
		end else if (reg_addr == pwm_pkg::compare_addr) begin
			reg_rdata <= compare_value;
		end else if (reg_addr == pwm_pkg::status_addr) begin
			reg_rdata <= {6'h00, compare_match_flag, overflow_flag};
		end else if (reg_addr == pwm_pkg::active_cmp_addr) begin
			reg_rdata <= compare_active;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// ==== pkg/pwm_pkg.sv ====
/*
 * Constants for the 8-bit timer PWM block: register offsets, field
 * positions, reset values, mode and prescaler encodings.
 * Assumes a single 40 MHz clock domain and a plain register port.
 */
package pwm_pkg;

	// --------------------------------------------------------------
	// register map (word offsets on the plain register port)
	// --------------------------------------------------------------
	localparam logic [2:0] ctrl_addr = 3'h0;
	localparam logic [2:0] counter_addr = 3'h1;
	localparam logic [2:0] compare_addr = 3'h2;
	localparam logic [2:0] status_addr = 3'h3;
	localparam logic [2:0] active_cmp_addr = 3'h4;

	// --------------------------------------------------------------
	// control field positions
	// --------------------------------------------------------------
	localparam int wgm_lsb = 0;
	localparam int com_lsb = 2;
	localparam int cs_lsb = 4;
	localparam int dir_bit = 7;

	// --------------------------------------------------------------
	// status bits: write one to clear
	// --------------------------------------------------------------
	localparam int ovf_bit = 0;
	localparam int cmf_bit = 1;

	// --------------------------------------------------------------
	// encodings and values
	// --------------------------------------------------------------
	localparam logic [1:0] wgm_normal = 2'h0;
	localparam logic [1:0] wgm_phase = 2'h1;
	localparam logic [1:0] wgm_ctc = 2'h2;
	localparam logic [1:0] wgm_fast = 2'h3;

	localparam logic [1:0] com_off = 2'h0;
	localparam logic [1:0] com_toggle = 2'h1;
	localparam logic [1:0] com_noninv = 2'h2;
	localparam logic [1:0] com_inv = 2'h3;

	localparam logic [2:0] cs_stop = 3'h0;
	localparam logic [2:0] cs_div1 = 3'h1;
	localparam logic [2:0] cs_div8 = 3'h2;
	localparam logic [2:0] cs_div64 = 3'h3;
	localparam logic [2:0] cs_div256 = 3'h4;
	localparam logic [2:0] cs_div1024 = 3'h5;

	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [7:0] bottom = 8'h00;
	localparam logic [7:0] max = 8'hFF;
	localparam int fast_period = 256;
	localparam int phase_period = 510;

	// prescaler counter is 10 bits wide for the 1024 division
	localparam logic [9:0] div8_mask = 10'h007;
	localparam logic [9:0] div64_mask = 10'h03F;
	localparam logic [9:0] div256_mask = 10'h0FF;
	localparam logic [9:0] div1024_mask = 10'h3FF;

endpackage

// ==== dv/pin_pad_model.sv ====
/* Port pad model for the timer compare pin.
   Assumes the pad has a pull-up and no other driver. */
`timescale 1ns/100ps
module pin_pad_model (
	input wire logic pin,
	input wire logic oe,
	output logic pad
);
	// an undriven pad floats to the pull-up, never to the last value
	assign pad = oe ? pin : 1'b1;
endmodule

// ==== dv/timer8_pwm_monitor.sv ====
/* Port checker for timer8_pwm, bound to every instance.
   Assumes one clock domain with synchronous reset. */
`timescale 1ns/100ps
module timer8_pwm_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic compare_output_pin,
	input wire logic compare_output_pin_oe,
	input wire logic overflow_flag,
	input wire logic compare_match_flag
);
	logic [7:0] ctl;
	logic [10:0] age;
	logic st_wr;
	assign st_wr = reg_wr && reg_addr == pwm_pkg::status_addr;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ----
	// shadow of control, age of quiet cycles since a config write
	// ----
	always_ff @(posedge clk) begin
		if (sys_rst)
			ctl <= pwm_pkg::ctrl_reset;
		else if (reg_wr && reg_addr == pwm_pkg::ctrl_addr)
			ctl <= reg_wdata;
	end
	// counter and compare writes also disturb the waveform
	always_ff @(posedge clk) begin
		if (sys_rst || (reg_wr && reg_addr < 3'h3))
			age <= 11'h000;
		else if (age != 11'h7FF)
			age <= age + 11'h001;
	end
	// ----
	// properties
	// ----
	sequence s_status_rd;
		reg_rd && reg_addr == pwm_pkg::status_addr;
	endsequence
	sequence s_steady_rise(logic [1:0] m, logic [10:0] a);
		age > a && ctl[1:0] == m && ctl[6:4] == pwm_pkg::cs_div1 && ctl[3]
			&& $rose(compare_output_pin);
	endsequence
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_unmapped_rd: assert property (reg_rd && reg_addr > 3'h4 |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_status_read: assert property (s_status_rd |=>
		reg_rdata == {6'h00, $past(compare_match_flag), $past(overflow_flag)})
		else $error("status read wrong");
	a_ovf_sticky: assert property (overflow_flag && !(st_wr && reg_wdata[0])
		|=> overflow_flag) else $error("overflow flag lost");
	a_cmf_sticky: assert property (compare_match_flag
		&& !(st_wr && reg_wdata[1]) |=> compare_match_flag)
		else $error("match flag lost");
	a_pin_release: assert property (age > 11'h002 && !ctl[7] |->
		!compare_output_pin_oe) else $error("pin driven while input");
	a_pin_drive: assert property (age > 11'h002 && ctl[7] && ctl[3]
		&& ctl[1:0] != 2'h0 |-> compare_output_pin_oe)
		else $error("pin not driven");
	a_fast_period: assert property (s_steady_rise(pwm_pkg::wgm_fast, 11'h258)
		|-> $past(compare_output_pin, 256) && !$past(compare_output_pin, 257))
		else $error("fast period wrong");
	a_phase_period: assert property (s_steady_rise(pwm_pkg::wgm_phase, 11'h4B0)
		|-> $past(compare_output_pin, 510) && !$past(compare_output_pin, 511))
		else $error("phase period wrong");
endmodule
bind timer8_pwm timer8_pwm_monitor i_timer8_pwm_monitor (.clk(clk),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.compare_output_pin(compare_output_pin),
	.compare_output_pin_oe(compare_output_pin_oe),
	.overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));

// ==== dv/timer8_pwm_bench.sv ====
/* Self-checking bench for timer8_pwm.
   Drives the register port; watches the pin through the pad model. */
`timescale 1ns/100ps
module timer8_pwm_bench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic pin, oe, ovf, cmf, pad;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	timer8_pwm i_timer8_pwm (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_output_pin(pin),
		.compare_output_pin_oe(oe), .overflow_flag(ovf),
		.compare_match_flag(cmf));
	pin_pad_model i_pin_pad_model (.pin(pin), .oe(oe), .pad(pad));
	// ----
	// shared tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			results();
		end
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// ctl = {dir, cs, com, wgm}; settle three periods, then measure one
	task automatic wave(input logic [7:0] ctl, input logic [7:0] cmp,
		input int p, input int hi_exp, input int rise_exp);
		logic [31:0] hi;
		logic [31:0] rise;
		logic prev;
		wr(pwm_pkg::compare_addr, cmp);
		wr(pwm_pkg::ctrl_addr, ctl);
		repeat (3 * p) @(posedge clk);
		hi = 0;
		rise = 0;
		#1;
		prev = pad;
		repeat (p) begin
			@(posedge clk);
			#1;
			hi = hi + {31'h0, pad};
			rise = rise + {31'h0, pad & ~prev};
			prev = pad;
		end
		check(hi, hi_exp);
		check(rise, rise_exp);
	endtask
	task automatic t_regs;
		logic [7:0] d;
		rd(pwm_pkg::ctrl_addr, d);
		check(d, pwm_pkg::ctrl_reset);
		rd(3'h7, d);
		check(d, 8'h00);
		// normal mode copies compare at once; fast mode, stopped, buffers it
		wr(pwm_pkg::compare_addr, 8'h22);
		wr(pwm_pkg::ctrl_addr, 8'h0B);
		wr(pwm_pkg::compare_addr, 8'h55);
		wr(pwm_pkg::active_cmp_addr, 8'h99);
		rd(pwm_pkg::active_cmp_addr, d);
		check(d, 8'h22);
		rd(pwm_pkg::compare_addr, d);
		check(d, 8'h55);
		rd(pwm_pkg::ctrl_addr, d);
		check(d, 8'h0B);
		wr(pwm_pkg::counter_addr, 8'hFD);
		rd(pwm_pkg::counter_addr, d);
		check(d, 8'hFD);
		wr(pwm_pkg::status_addr, 8'h03);
		rd(pwm_pkg::status_addr, d);
		check(d, 8'h00);
		wr(pwm_pkg::ctrl_addr, 8'h1B);
		repeat (10) @(posedge clk);
		rd(pwm_pkg::status_addr, d);
		check(d & 8'h01, 8'h01);
		repeat (300) @(posedge clk);
		rd(pwm_pkg::active_cmp_addr, d);
		check(d, 8'h55);
		check({31'h0, ovf}, 32'h1);
		rd(pwm_pkg::status_addr, d);
		check(d & 8'h02, 8'h02);
		check({31'h0, cmf}, 32'h1);
		wr(pwm_pkg::ctrl_addr, 8'h19);
		wr(pwm_pkg::status_addr, 8'h03);
		repeat (520) @(posedge clk);
		rd(pwm_pkg::status_addr, d);
		check(d & 8'h01, 8'h01);
		check({31'h0, ovf}, 32'h1);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		wave(8'h9B, 8'h40, 256, 65, 1);
		wave(8'h9F, 8'h40, 256, 191, 1);
		wave(8'h9B, 8'h00, 256, 1, 1);
		wave(8'h9B, 8'hFF, 256, 256, 0);
		wave(8'h9F, 8'hFF, 256, 0, 0);
		wave(8'h97, 8'h00, 512, 256, 1);
		wave(8'hAB, 8'h40, 2048, 520, 1);
		wave(8'h1B, 8'h40, 256, 256, 0);
		wave(8'h99, 8'h40, 510, 128, 1);
		wave(8'h9D, 8'h40, 510, 382, 1);
		wave(8'h99, 8'h00, 510, 0, 0);
		wave(8'h99, 8'hFF, 510, 510, 0);
		wave(8'h9D, 8'h00, 510, 510, 0);
		results();
	end
endmodule
